/* File: rtl/wcd_detector.sv */
// Wake-up card presence detector: timer, field burst, compare and averaging.
module wcd_detector #(
   parameter int FIELD_CYCLES = wcd_pkg::FIELD_CYC
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic rc_tick,
   input wire wcd_pkg::wcd_bus_s bus,
   output logic [7:0] rdata,
   input wire logic meas_done,
   input wire logic [7:0] meas_val,
   output wcd_pkg::wcd_meas_s meas,
   output logic irq
);
   import wcd_pkg::*;

   // All state of the block, registered as one word.
   typedef struct packed {
      wcd_state_e st;
      logic [7:0] opctl;
      logic [7:0] wutc;
      logic [1:0][7:0] cfg;
      logic [1:0][7:0] href;
      // Averaged references carry two fraction bits below the displayed value.
      logic [1:0][REF_W-1:0] aref;
      logic [1:0][7:0] res;
      // Reference initialisation pending, bit 0 amplitude and bit 1 phase.
      logic [1:0] first;
      // Sticky status: amplitude hit, phase hit and timer expiry.
      logic [2:0] ist;
      logic [2:0] imsk;
      logic halted;
      // Timer ticks since the last expiry and cycles into the current burst.
      logic [14:0] tcnt;
      logic [12:0] fcnt;
      // Method of the current burst, then its captured result.
      logic sel;
      logic got;
      logic [7:0] mv;
      wcd_meas_s meas;
      logic irq;
      logic [7:0] rdata;
   } wcd_regs_s;

   wcd_regs_s s_r;
   wcd_regs_s s_nxt;

   // ==========================================
   // Helpers
   // Interval code to RC tick count: 10,20,50,100,200,300,400,800 ms.
   function automatic logic [14:0] wcd_period(input logic [2:0] code);
      logic [4:0] mult;
      mult = 5'h01;
      case (code)
         3'h0: mult = 5'h01;
         3'h1: mult = 5'h02;
         3'h2: mult = 5'h05;
         3'h3: mult = 5'h0A;
         3'h4: mult = 5'h14;
         3'h5: mult = 5'h1E;
         3'h6: mult = 5'h28;
         default: mult = 5'h50;
      endcase
      wcd_period = 15'(PER_10MS * mult);
   endfunction

   // Weight code to divisor 1, 2, 4 or 8.
   function automatic logic [REF_W-1:0] wcd_avg(input logic [REF_W-1:0] old_ref,
                                               input logic [7:0] mval,
                                               input logic [1:0] wcode);
      logic signed [REF_W+1:0] diff;
      logic signed [REF_W+1:0] step;
      // Twelve signed bits keep the difference from wrapping; the quotient truncates to zero.
      diff = $signed({2'h0, old_ref}) - $signed({2'h0, mval, 2'h0});
      step = diff / $signed(12'(4'h1 << wcode));
      wcd_avg = REF_W'($signed({2'h0, old_ref}) - step);
   endfunction

   // Unsigned distance between two eight-bit values.
   function automatic logic [7:0] wcd_absdiff(input logic [7:0] a, input logic [7:0] b);
      wcd_absdiff = (a > b) ? 8'(a - b) : 8'(b - a);
   endfunction

   // Splits an offset of the method groups into method and register index.
   function automatic logic [2:0] wcd_grp(input logic [7:0] addr);
      logic [7:0] rel;
      rel = 8'(addr - OFS_AMP_CFG);
      wcd_grp = rel[2:0];
   endfunction

   // ==========================================
   // Next-state logic
   logic active;
   logic wu_rise;
   // Scratch values of the comparison and of the group decode.
   logic [7:0] refv;
   logic hit;
   logic [1:0] gi;
   logic gm;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.meas.meas_req = 1'b0;
      s_nxt.rdata = 8'h00;
      active = (s_r.opctl == OPCTL_WU_ONLY);
      wu_rise = 1'b0;
      refv = 8'h00;
      hit = 1'b0;
      gi = 2'h0;
      gm = 1'b0;

      // Register writes.
      if (bus.wr)
      begin
         if (bus.addr == OFS_OPCTL)
         begin
            s_nxt.opctl = bus.wdata;
            wu_rise = bus.wdata[OPCTL_WU_BIT] & ~s_r.opctl[OPCTL_WU_BIT];
         end
         else if (bus.addr == OFS_IRQ_MSK)
         begin
            s_nxt.imsk = bus.wdata[2:0];
         end
         else if (bus.addr == OFS_CMD)
         begin
            if (bus.wdata == CMD_HALT_ALL)
            begin
               s_nxt.halted = 1'b1;
            end
         end
         else if (bus.addr == OFS_WUTC)
         begin
            s_nxt.wutc = bus.wdata;
         end
         else if (bus.addr >= OFS_AMP_CFG && bus.addr < OFS_WSTAT)
         begin
            {gm, gi} = wcd_grp(bus.addr);
            if (gi == GRP_CFG)
            begin
               s_nxt.cfg[gm] = bus.wdata;
            end
            else if (gi == GRP_REF)
            begin
               s_nxt.href[gm] = bus.wdata;
            end
         end
      end

      // Rising wake bit re-arms reference initialisation and releases a halt.
      if (wu_rise)
      begin
         s_nxt.first = 2'h3;
         s_nxt.halted = 1'b0;
      end

      // Register reads, data valid in the following cycle.
      if (bus.rd)
      begin
         if (bus.addr == OFS_OPCTL)
         begin
            s_nxt.rdata = s_r.opctl;
         end
         else if (bus.addr == OFS_IRQ_ST)
         begin
            s_nxt.rdata = {5'h00, s_r.ist};
         end
         else if (bus.addr == OFS_IRQ_MSK)
         begin
            s_nxt.rdata = {5'h00, s_r.imsk};
         end
         else if (bus.addr == OFS_WUTC)
         begin
            s_nxt.rdata = s_r.wutc;
         end
         else if (bus.addr >= OFS_AMP_CFG && bus.addr < OFS_WSTAT)
         begin
            // Group order: configuration, host reference, averaged reference, last result.
            {gm, gi} = wcd_grp(bus.addr);
            if (gi == GRP_CFG)
            begin
               s_nxt.rdata = s_r.cfg[gm];
            end
            else if (gi == GRP_REF)
            begin
               s_nxt.rdata = s_r.href[gm];
            end
            else if (gi == GRP_AUTO)
            begin
               s_nxt.rdata = s_r.aref[gm][REF_W-1:2];
            end
            else
            begin
               s_nxt.rdata = s_r.res[gm];
            end
         end
         else if (bus.addr == OFS_LAST)
         begin
            s_nxt.rdata = {4'h0, s_r.halted, s_r.meas.field_on, s_r.first};
         end
      end

      // Detection sequencer.
      case (s_r.st)
         WCD_IDLE:
         begin
            // The timer restarts from zero on every entry into the mode.
            s_nxt.tcnt = 15'h0000;
            if (active && !s_r.halted)
            begin
               s_nxt.st = WCD_WAIT;
            end
         end
         WCD_WAIT:
         begin
            if (rc_tick)
            begin
               if (s_r.tcnt >= 15'(wcd_period(s_r.wutc[WUTC_PER_LSB+:3]) - 15'h0001))
               begin
                  s_nxt.tcnt = 15'h0000;
                  // The expiry flag rises even when no method is enabled.
                  s_nxt.ist[IRQ_WT] = 1'b1;
                  s_nxt.fcnt = 13'h0000;
                  s_nxt.got = 1'b0;
                  if (s_r.wutc[WUTC_AMP_EN] || s_r.wutc[WUTC_PH_EN])
                  begin
                     s_nxt.sel = ~s_r.wutc[WUTC_AMP_EN];
                     s_nxt.st = WCD_FIELD;
                     s_nxt.meas.field_on = 1'b1;
                     s_nxt.meas.meas_req = 1'b1;
                     s_nxt.meas.meas_phase = ~s_r.wutc[WUTC_AMP_EN];
                  end
               end
               else
               begin
                  s_nxt.tcnt = 15'(s_r.tcnt + 15'h0001);
               end
            end
         end
         WCD_FIELD:
         begin
            // Only the first result of a burst counts; later pulses are ignored.
            if (meas_done && !s_r.got)
            begin
               s_nxt.got = 1'b1;
               s_nxt.mv = meas_val;
            end
            if (s_r.fcnt >= 13'(FIELD_CYCLES - 1))
            begin
               s_nxt.meas.field_on = 1'b0;
               s_nxt.st = WCD_EVAL;
            end
            else
            begin
               s_nxt.fcnt = 13'(s_r.fcnt + 13'h0001);
            end
         end
         WCD_EVAL:
         begin
            // A burst without a result leaves references and status untouched.
            if (s_r.got)
            begin
               s_nxt.res[s_r.sel] = s_r.mv;
               if (s_r.cfg[s_r.sel][CFG_AUTO] && s_r.first[s_r.sel])
               begin
                  s_nxt.aref[s_r.sel] = {s_r.mv, 2'h0};
                  s_nxt.first[s_r.sel] = 1'b0;
               end
               else
               begin
                  // The comparison base is the averaged display value or the host value.
                  refv = s_r.cfg[s_r.sel][CFG_AUTO] ? s_r.aref[s_r.sel][REF_W-1:2]
                                                    : s_r.href[s_r.sel];
                  hit = wcd_absdiff(s_r.mv, refv) >
                        {4'h0, s_r.cfg[s_r.sel][CFG_THR_LSB+:4]};
                  if (hit)
                  begin
                     s_nxt.ist[s_r.sel] = 1'b1;
                  end
                  // A triggering result enters the average only when its method asks.
                  if (s_r.cfg[s_r.sel][CFG_AUTO] && (!hit || s_r.cfg[s_r.sel][CFG_INC]))
                  begin
                     s_nxt.aref[s_r.sel] = wcd_avg(s_r.aref[s_r.sel], s_r.mv,
                                                   s_r.cfg[s_r.sel][1:0]);
                  end
               end
            end
            s_nxt.fcnt = 13'h0000;
            s_nxt.got = 1'b0;
            // Amplitude runs first; a phase burst follows at once when enabled.
            if (!s_r.sel && s_r.wutc[WUTC_PH_EN])
            begin
               s_nxt.sel = 1'b1;
               s_nxt.st = WCD_FIELD;
               s_nxt.meas.field_on = 1'b1;
               s_nxt.meas.meas_req = 1'b1;
               s_nxt.meas.meas_phase = 1'b1;
            end
            else
            begin
               s_nxt.st = WCD_WAIT;
            end
         end
         default:
         begin
            s_nxt.st = WCD_IDLE;
         end
      endcase

      // Leaving the mode or halting stops the timer and drops the field.
      // A halt written in the very cycle of an expiry keeps the burst from starting.
      if (!active || s_nxt.halted)
      begin
         s_nxt.st = WCD_IDLE;
         s_nxt.meas.field_on = 1'b0;
         s_nxt.meas.meas_req = 1'b0;
         s_nxt.tcnt = 15'h0000;
      end

      // Write-one-to-clear; a new event in the same cycle wins only on a flag that was clear, and a set flag is still cleared.
      if (bus.wr && bus.addr == OFS_IRQ_ST)
      begin
         s_nxt.ist = (s_r.ist & ~bus.wdata[2:0]) | (s_nxt.ist & ~s_r.ist);
      end
      s_nxt.irq = |(s_nxt.ist & s_nxt.imsk);
   end

   // ==========================================
   // State register
   // Reset loads the power-on defaults; a low clock enable freezes every field.
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_r <= '0;
         s_r.st <= WCD_IDLE;
         s_r.wutc <= WUTC_RST;
         s_r.first <= 2'h3;
      end
      else if (clk_en)
      begin
         s_r <= s_nxt;
      end
   end

   // ==========================================
   // Outputs
   // Every output is a field of the state register.
   assign rdata = s_r.rdata;
   assign meas = s_r.meas;
   assign irq = s_r.irq;
endmodule

/* File: rtl/wcd_pkg.sv */
// Package: register map, field layouts and timing of the wake-up detector.
package wcd_pkg;
   // ==========================================
   // Register offsets
   localparam logic [7:0] OFS_OPCTL = 8'h02;
   localparam logic [7:0] OFS_IRQ_ST = 8'h1A;
   localparam logic [7:0] OFS_IRQ_MSK = 8'h1B;
   localparam logic [7:0] OFS_CMD = 8'h1C;
   localparam logic [7:0] OFS_WUTC = 8'h32;
   localparam logic [7:0] OFS_AMP_CFG = 8'h33;
   localparam logic [7:0] OFS_PH_CFG = 8'h37;
   localparam logic [7:0] OFS_WSTAT = 8'h3B;
   localparam logic [7:0] OFS_LAST = 8'h3B;
   // Register offset within a four-register method group.
   localparam logic [1:0] GRP_CFG = 2'h0;
   localparam logic [1:0] GRP_REF = 2'h1;
   localparam logic [1:0] GRP_AUTO = 2'h2;
   localparam logic [1:0] GRP_RES = 2'h3;
   // ==========================================
   // Field layouts and values
   localparam logic [7:0] OPCTL_WU_ONLY = 8'h04;
   localparam int OPCTL_WU_BIT = 2;
   localparam logic [7:0] CMD_HALT_ALL = 8'hC2;
   localparam int WUTC_PER_LSB = 4;
   localparam int WUTC_PH_EN = 3;
   localparam int WUTC_AMP_EN = 2;
   localparam logic [7:0] WUTC_RST = 8'h34;
   localparam int CFG_THR_LSB = 4;
   localparam int CFG_INC = 3;
   localparam int CFG_AUTO = 2;
   localparam int IRQ_AMP = 0;
   localparam int IRQ_PH = 1;
   localparam int IRQ_WT = 2;
   localparam int REF_W = 10;
   // ==========================================
   // Timing
   localparam int RC_KHZ = 32;
   localparam int CLK_MHZ = 250;
   localparam int FIELD_US = 20;
   localparam int FIELD_CYC = FIELD_US * CLK_MHZ;
   localparam logic [14:0] PER_10MS = 15'h0140;
   // ==========================================
   // Types
   typedef enum logic [2:0] {WCD_IDLE, WCD_WAIT, WCD_FIELD, WCD_EVAL} wcd_state_e;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } wcd_bus_s;
   typedef struct packed {
      logic field_on;
      logic meas_req;
      logic meas_phase;
   } wcd_meas_s;
endpackage

/* File: tb/testbench.sv */
// Self-checking testbench of the wake-up detector.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import wcd_pkg::*;
   logic core_clk, nrst, rc_tick, meas_done, irq, ph;
   wcd_bus_s bus;
   wcd_meas_s meas;
   logic [7:0] rdata, meas_val, val;
   logic [3:0] dly;
   int n_fail = 0;
   int checked = 0;
   int n_req = 0;
   int n0;
   wcd_detector #(.FIELD_CYCLES(8)) i_wcd_detector (.core_clk(core_clk), .nrst(nrst),
      .clk_en(1'b1), .rc_tick(rc_tick), .bus(bus), .rdata(rdata), .meas_done(meas_done),
      .meas_val(meas_val), .meas(meas), .irq(irq));
   wcd_meas_model i_wcd_meas_model (.core_clk(core_clk), .nrst(nrst), .meas(meas),
      .val(val), .dly(dly), .done(meas_done), .mval(meas_val));
   // ==========================================
   // Clock, ticks and shared tasks
   initial
   begin
      core_clk = 1'b0;
      rc_tick = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      rc_tick <= ~rc_tick;
      if (meas.meas_req === 1'b1)
         n_req++;
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge core_clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] m,
      input logic [7:0] e);
      @(posedge core_clk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge core_clk);
      bus.rd <= 1'b0;
      #1 chk(nm, rdata & m, e);
   endtask
   task automatic burst();
      int k;
      k = 0;
      while (meas.meas_req !== 1'b1 && k < 3000)
      begin
         @(posedge core_clk);
         #1 k++;
      end
      chk("burst", 8'(k == 3000), 8'h00);
      ph = meas.meas_phase;
      repeat (16) @(posedge core_clk);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset();
      rdc("timer", OFS_WUTC, 8'hFF, WUTC_RST);
      rdc("wstat", OFS_WSTAT, 8'hFF, 8'h03);
      rdc("unmapped", 8'h50, 8'hFF, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_refuse();
      wr(OFS_WUTC, 8'h04);
      wr(OFS_AMP_CFG, 8'h25);
      wr(OFS_IRQ_MSK, 8'h01);
      n0 = n_req;
      wr(OFS_OPCTL, 8'h05);
      repeat (800) @(posedge core_clk);
      chk("refused", 8'(n_req - n0), 8'h00);
      wr(OFS_OPCTL, 8'h00);
      $display("test refuse done");
   endtask
   task automatic t_auto();
      val = 8'd100;
      wr(OFS_OPCTL, OPCTL_WU_ONLY);
      burst();
      val = 8'd102;
      rdc("init ref", 8'h35, 8'hFF, 8'd100);
      chk("no first irq", {7'h0, irq}, 8'h00);
      burst();
      val = 8'd110;
      chk("edge irq", {7'h0, irq}, 8'h00);
      rdc("avg ref", 8'h35, 8'hFF, 8'd101);
      burst();
      chk("hit irq", {7'h0, irq}, 8'h01);
      rdc("hit st", OFS_IRQ_ST, 8'h01, 8'h01);
      rdc("excluded", 8'h35, 8'hFF, 8'd101);
      rdc("last", 8'h36, 8'hFF, 8'd110);
      wr(OFS_IRQ_ST, 8'h07);
      repeat (2) @(posedge core_clk);
      #1 chk("cleared", {7'h0, irq}, 8'h00);
      $display("test auto done");
   endtask
   task automatic t_halt();
      wr(OFS_CMD, CMD_HALT_ALL);
      rdc("halted", OFS_WSTAT, 8'h08, 8'h08);
      n0 = n_req;
      repeat (800) @(posedge core_clk);
      chk("halt quiet", 8'(n_req - n0), 8'h00);
      $display("test halt done");
   endtask
   task automatic t_phase();
      wr(OFS_OPCTL, 8'h00);
      wr(OFS_WUTC, 8'h08);
      wr(OFS_PH_CFG, 8'h30);
      wr(8'h38, 8'd50);
      wr(OFS_IRQ_MSK, 8'h02);
      dly = 4'h5;
      val = 8'd54;
      wr(OFS_OPCTL, OPCTL_WU_ONLY);
      burst();
      chk("phase", {7'h0, ph}, 8'h01);
      chk("host ref irq", {7'h0, irq}, 8'h01);
      rdc("ph last", 8'h3A, 8'hFF, 8'd54);
      $display("test phase done");
   endtask
   // ==========================================
   // Main sequence and watchdog
   initial
   begin
      nrst = 1'b0;
      bus = '0;
      val = 8'h00;
      dly = 4'h2;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      t_reset();
      t_refuse();
      t_auto();
      t_halt();
      t_phase();
      test_done();
   end
   initial
   begin
      #100000;
      chk("watchdog", 8'h01, 8'h00);
      test_done();
   end
endmodule

/* File: tb/wcd_detector_props.sv */
// Checker of the wake-up detector port behaviour.
module wcd_detector_props
#(
   parameter int FIELD_CYCLES = 8
)
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic rc_tick,
   input wire wcd_pkg::wcd_bus_s bus,
   input wire logic [7:0] rdata,
   input wire logic meas_done,
   input wire logic [7:0] meas_val,
   input wire wcd_pkg::wcd_meas_s meas,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   import wcd_pkg::*;
   int fcnt;
   logic [7:0] wcap;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   // ==========================================
   // Burst length counter and timer register shadow
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         fcnt <= 0;
         wcap <= WUTC_RST;
      end
      else if (clk_en)
      begin
         fcnt <= meas.field_on ? fcnt + 1 : 0;
         if (bus.wr && bus.addr == OFS_WUTC)
            wcap <= bus.wdata;
      end
   end
   // ==========================================
   // Properties
   sequence s_halt;
      bus.wr && bus.addr == OFS_CMD && bus.wdata == CMD_HALT_ALL && !meas.field_on;
   endsequence
   sequence s_quiet;
      !meas.meas_req [*8];
   endsequence
   a_req_field: assert property ($rose(meas.field_on) |-> meas.meas_req)
      else $error("field rose without request");
   a_req_pulse: assert property (meas.meas_req |=> !meas.meas_req)
      else $error("request longer than one cycle");
   a_field_width: assert property ($fell(meas.field_on) |-> fcnt == FIELD_CYCLES)
      else $error("field burst length wrong");
   a_phase_steady: assert property (meas.field_on && $past(meas.field_on)
      |-> $stable(meas.meas_phase))
      else $error("method changed in burst");
   a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
      else $error("read data without read");
   a_unmapped_zero: assert property (bus.rd && bus.addr > OFS_LAST |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_timer_back: assert property (bus.rd && bus.addr == OFS_WUTC
      |=> rdata[6:2] == $past(wcap[6:2]))
      else $error("timer register readback wrong");
   a_halt_stops: assert property (s_halt |=> s_quiet)
      else $error("burst after halt");
   a_irq_fall: assert property ($fell(irq) |-> $past(bus.wr) || $past(bus.wr, 2))
      else $error("interrupt fell without write");
endmodule
bind wcd_detector wcd_detector_props #(.FIELD_CYCLES(FIELD_CYCLES)) i_wcd_detector_props (
   .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .rc_tick(rc_tick), .bus(bus),
   .rdata(rdata), .meas_done(meas_done), .meas_val(meas_val), .meas(meas), .irq(irq));

/* File: tb/wcd_meas_model.sv */
// Behavioural analog measurer answering each burst request.
module wcd_meas_model
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire wcd_pkg::wcd_meas_s meas,
   input wire logic [7:0] val,
   input wire logic [3:0] dly,
   output logic done,
   output logic [7:0] mval
);
   timeunit 1ns;
   timeprecision 1ps;
   import wcd_pkg::*;
   int cnt;
   // The result bus toggles outside its valid cycle so stale data cannot pass.
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt <= 0;
         done <= 1'b0;
         mval <= 8'h00;
      end
      else
      begin
         cnt <= meas.meas_req ? dly + 1 : (cnt > 0 ? cnt - 1 : 0);
         done <= (cnt == 1);
         mval <= (cnt == 1) ? val : ~mval;
      end
   end
endmodule
